// file: hdl/nvsac_defines.svh
`ifndef NVSAC_DEFINES_SVH
`define NVSAC_DEFINES_SVH

// Clock rate in MHz
`define NVSAC_CLK_MHZ       25
// Unlock prefix addresses and final selectors
`define NVSAC_SEQ_A0        15'h0e38
`define NVSAC_SEQ_A1        15'h31c7
`define NVSAC_SEQ_A2        15'h03e0
`define NVSAC_SEQ_A3        15'h3c1f
`define NVSAC_SEQ_A4        15'h303f
`define NVSAC_SEQ_STORE     15'h0fc0
`define NVSAC_SEQ_RECALL    15'h0c63
`define NVSAC_SEQ_TEST      15'h339c
// Timing in ns, us or ms, then cycles derived (min rounds up, max rounds down)
`define NVSAC_T_CYCLE_NS    35
`define NVSAC_T_CYCLE_CYC   ((`NVSAC_T_CYCLE_NS * `NVSAC_CLK_MHZ + 999) / 1000)
`define NVSAC_T_DIS_NS      13
`define NVSAC_T_EN_W_NS     5
`define NVSAC_T_EN_W_CYC    ((`NVSAC_T_EN_W_NS * `NVSAC_CLK_MHZ + 999) / 1000)
`define NVSAC_T_HSB_PW_NS   20
`define NVSAC_T_HSB_PW_CYC  ((`NVSAC_T_HSB_PW_NS * `NVSAC_CLK_MHZ + 999) / 1000)
`define NVSAC_T_INH_ON_US   1
`define NVSAC_T_INH_ON_CYC  (`NVSAC_T_INH_ON_US * `NVSAC_CLK_MHZ)
`define NVSAC_T_INH_OFF_NS  700
`define NVSAC_T_INH_OFF_CYC ((`NVSAC_T_INH_OFF_NS * `NVSAC_CLK_MHZ + 999) / 1000)
`define NVSAC_T_STORE_MS    10
`define NVSAC_T_STORE_CYC   (`NVSAC_T_STORE_MS * 1000 * 1000 * `NVSAC_CLK_MHZ / 1000)
`define NVSAC_T_PURCL_US    650
`define NVSAC_T_PURCL_CYC   (`NVSAC_T_PURCL_US * `NVSAC_CLK_MHZ)
`define NVSAC_CNT_W         18

`endif

// file: hdl/nvsac_pkg.sv
package nvsac_pkg;

    // Host command codes
    typedef enum logic [2:0] {
        NVSAC_CMD_READ   = 3'b000,
        NVSAC_CMD_WRITE  = 3'b001,
        NVSAC_CMD_STORE  = 3'b010,
        NVSAC_CMD_RECALL = 3'b011,
        NVSAC_CMD_HWSTR  = 3'b100
    } nvsac_cmd_t;

    // One host request
    typedef struct packed {
        nvsac_cmd_t  cmd;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } nvsac_req_t;

    // Controller states
    typedef enum logic [3:0] {
        NVSAC_S_PWRUP  = 4'b0000,
        NVSAC_S_IDLE   = 4'b0001,
        NVSAC_S_SETUP  = 4'b0010,
        NVSAC_S_STROBE = 4'b0011,
        NVSAC_S_GAP    = 4'b0100,
        NVSAC_S_NVWAIT = 4'b0101,
        NVSAC_S_HSBLOW = 4'b0110,
        NVSAC_S_HSBWT  = 4'b0111,
        NVSAC_S_INHOFF = 4'b1000
    } nvsac_state_t;

endpackage

// file: hdl/nvsac_host.sv
`timescale 1ns/1ns
`include "nvsac_defines.svh"

// Overview of operation
// - Six reads ending 0FC0 start store
// - Six reads ending 0C63 start recall
// - No write strobe inside unlock sequence
// - Never issue test sequence ending 339C
// - Hold busy line low at least 20 ns
module nvsac_host
    import nvsac_pkg::*;
#(
    parameter int STORE_CYC = `NVSAC_T_STORE_CYC,  // Longest store wait
    parameter int PURCL_CYC = `NVSAC_T_PURCL_CYC   // Power-up recall wait
) (
    input  wire logic             CLK,
    input  wire logic             ARST_N,
    input  wire nvsac_pkg::nvsac_req_t REQ,
    input  wire logic             REQ_VALID,
    output logic                  REQ_READY,
    output logic [7:0]            RDATA,
    output logic                  RDATA_VALID,
    output logic                  DONE,
    output logic [14:0]           A,
    output logic [7:0]            DQ_O,
    output logic                  DQ_OE,
    input  wire logic [7:0]       DQ_I,
    output logic                  SEL_N,
    output logic                  WR_N,
    output logic                  GATE_N,
    output logic                  HSB_O,
    output logic                  HSB_OE,
    input  wire logic             HSB_I
);
    import nvsac_pkg::*;

    localparam logic [`NVSAC_CNT_W-1:0] CYC_ACC = `NVSAC_CNT_W'(`NVSAC_T_CYCLE_CYC);
    localparam logic [`NVSAC_CNT_W-1:0] CYC_ENW = `NVSAC_CNT_W'(`NVSAC_T_EN_W_CYC);
    localparam logic [`NVSAC_CNT_W-1:0] CYC_HPW = `NVSAC_CNT_W'(`NVSAC_T_HSB_PW_CYC);
    localparam logic [`NVSAC_CNT_W-1:0] CYC_INH = `NVSAC_CNT_W'(`NVSAC_T_INH_ON_CYC);
    localparam logic [`NVSAC_CNT_W-1:0] CYC_OFF = `NVSAC_CNT_W'(`NVSAC_T_INH_OFF_CYC);

    // Unlock address table, index 5 is replaced by the selector
    logic [14:0]             seq_rom [0:4];
    assign seq_rom[0] = `NVSAC_SEQ_A0;
    assign seq_rom[1] = `NVSAC_SEQ_A1;
    assign seq_rom[2] = `NVSAC_SEQ_A2;
    assign seq_rom[3] = `NVSAC_SEQ_A3;
    assign seq_rom[4] = `NVSAC_SEQ_A4;

    nvsac_state_t            state_reg;     // Sequencer state
    nvsac_req_t              req_reg;       // Request being served
    logic [2:0]              seq_idx_reg;   // Unlock step, 0..5
    logic [31:0]             cnt_reg;       // Shared interval counter
    logic [2:0]              hsb_sync_reg;  // Busy line synchroniser
    logic [7:0]              dq_sync1_reg;  // Read data stage one
    logic [7:0]              dq_sync2_reg;  // Read data stage two
    logic [7:0]              dq_sync3_reg;  // Read data stage three
    logic                    hsb_high;      // Filtered busy line level
    logic                    is_seq;        // Request is an unlock sequence
    logic                    seq_last;      // Sixth access of sequence
    logic [14:0]             seq_addr;      // Address of this unlock step

    ////////////////////////////////////////////////////////////////////////
    // Busy line sampled off-domain; change counts when stages 2,3 agree
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hsb_sync_reg <= 3'h7;
            hsb_high     <= 1'b1;
        end else begin
            hsb_sync_reg <= {hsb_sync_reg[1:0], HSB_I};
            if (hsb_sync_reg[1] == hsb_sync_reg[2]) begin
                hsb_high <= hsb_sync_reg[2];
            end
        end
    end

    // Read data passes three stages; device holds it steady during strobe,
    // so the last stage is settled one cycle before the strobe ends
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dq_sync1_reg <= 8'h00;
            dq_sync2_reg <= 8'h00;
            dq_sync3_reg <= 8'h00;
        end else begin
            dq_sync1_reg <= DQ_I;
            dq_sync2_reg <= dq_sync1_reg;
            dq_sync3_reg <= dq_sync2_reg;
        end
    end

    assign is_seq   = (req_reg.cmd == NVSAC_CMD_STORE) || (req_reg.cmd == NVSAC_CMD_RECALL);
    assign seq_last = (seq_idx_reg == 3'h5);
    // Only store or recall selectors exist, so the test tail is unreachable
    always_comb begin
        if (!seq_last) begin
            seq_addr = seq_rom[seq_idx_reg];
        end else if (req_reg.cmd == NVSAC_CMD_STORE) begin
            seq_addr = `NVSAC_SEQ_STORE;
        end else begin
            seq_addr = `NVSAC_SEQ_RECALL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequencer
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg   <= NVSAC_S_PWRUP;
            req_reg     <= '0;
            seq_idx_reg <= 3'h0;
            cnt_reg     <= 32'h0;
            REQ_READY   <= 1'b0;
            RDATA       <= 8'h00;
            RDATA_VALID <= 1'b0;
            DONE        <= 1'b0;
            A           <= 15'h0000;
            DQ_O        <= 8'h00;
            DQ_OE       <= 1'b0;
            SEL_N       <= 1'b1;
            WR_N        <= 1'b1;
            GATE_N      <= 1'b1;
            HSB_O       <= 1'b0;
            HSB_OE      <= 1'b0;
        end else begin
            RDATA_VALID <= 1'b0;
            DONE        <= 1'b0;
            unique case (state_reg)
                // Wait out the automatic recall before any access
                NVSAC_S_PWRUP: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg >= 32'(PURCL_CYC - 1)) begin
                        cnt_reg   <= 32'h0;
                        REQ_READY <= 1'b1;
                        state_reg <= NVSAC_S_IDLE;
                    end
                end
                // Accept only while the busy line is released
                NVSAC_S_IDLE: begin
                    if (REQ_VALID && REQ_READY && hsb_high) begin
                        req_reg     <= REQ;
                        REQ_READY   <= 1'b0;
                        seq_idx_reg <= 3'h0;
                        cnt_reg     <= 32'h0;
                        if (REQ.cmd == NVSAC_CMD_HWSTR) begin
                            HSB_OE    <= 1'b1;
                            state_reg <= NVSAC_S_HSBLOW;
                        end else begin
                            state_reg <= NVSAC_S_SETUP;
                        end
                    end
                end
                // Address and select low are set on the same edge; write strobe stays high
                NVSAC_S_SETUP: begin
                    A       <= is_seq ? seq_addr : req_reg.addr;
                    WR_N    <= 1'b1;
                    GATE_N  <= is_seq | (req_reg.cmd == NVSAC_CMD_WRITE) ? 1'b1 : 1'b0;
                    cnt_reg <= 32'h0;
                    // Select falls first, then write strobe: device floats
                    SEL_N     <= 1'b0;
                    state_reg <= NVSAC_S_STROBE;
                end
                // Hold strobes for the access time plus four cycles for read data to settle
                NVSAC_S_STROBE: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (req_reg.cmd == NVSAC_CMD_WRITE && cnt_reg == 32'h0) begin
                        WR_N  <= 1'b0;
                        DQ_O  <= req_reg.wdata;
                    end
                    if (req_reg.cmd == NVSAC_CMD_WRITE && cnt_reg == 32'h1) begin
                        DQ_OE <= 1'b1;
                    end
                    if (cnt_reg >= 32'(CYC_ACC) + 32'h3) begin
                        if (req_reg.cmd == NVSAC_CMD_READ) begin
                            RDATA       <= dq_sync3_reg;
                            RDATA_VALID <= 1'b1;
                        end
                        // One clean select pulse per address, no glitches
                        SEL_N     <= 1'b1;
                        WR_N      <= 1'b1;
                        GATE_N    <= 1'b1;
                        cnt_reg   <= 32'h0;
                        state_reg <= NVSAC_S_GAP;
                    end
                end
                // Release data bus, then space the next access
                NVSAC_S_GAP: begin
                    DQ_OE   <= 1'b0;
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg >= 32'(CYC_ENW)) begin
                        cnt_reg <= 32'h0;
                        if (is_seq && !seq_last) begin
                            seq_idx_reg <= seq_idx_reg + 3'h1;
                            state_reg   <= NVSAC_S_SETUP;
                        end else if (is_seq) begin
                            // Software store runs even without writes
                            state_reg <= NVSAC_S_NVWAIT;
                        end else begin
                            DONE      <= 1'b1;
                            REQ_READY <= 1'b1;
                            state_reg <= NVSAC_S_IDLE;
                        end
                    end
                end
                // Device runs on its own; pins stay idle meanwhile
                NVSAC_S_NVWAIT: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg >= 32'(STORE_CYC - 1)) begin
                        cnt_reg   <= 32'h0;
                        DONE      <= 1'b1;
                        REQ_READY <= 1'b1;
                        state_reg <= NVSAC_S_IDLE;
                    end
                end
                // Pull busy line low for the longer of pulse width and inhibit-on time
                NVSAC_S_HSBLOW: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg >= 32'(CYC_HPW) && cnt_reg >= 32'(CYC_INH)) begin
                        HSB_OE    <= 1'b0;
                        cnt_reg   <= 32'h0;
                        state_reg <= NVSAC_S_HSBWT;
                    end
                end
                // Device may hold the line low while storing
                NVSAC_S_HSBWT: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if ((hsb_high && cnt_reg >= 32'h4) || cnt_reg >= 32'(STORE_CYC - 1)) begin
                        cnt_reg   <= 32'h0;
                        state_reg <= NVSAC_S_INHOFF;
                    end
                end
                // Allow the device to leave inhibit before the next access
                NVSAC_S_INHOFF: begin
                    cnt_reg <= cnt_reg + 32'h1;
                    if (!hsb_high) begin
                        cnt_reg <= 32'h0;
                    end else if (cnt_reg >= 32'(CYC_OFF)) begin
                        cnt_reg   <= 32'h0;
                        DONE      <= 1'b1;
                        REQ_READY <= 1'b1;
                        state_reg <= NVSAC_S_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// file: sim/nvsac_host_properties.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Pin timing checks on the host side of the nonvolatile SRAM
module nvsac_host_properties
    import nvsac_pkg::*;
#(
    parameter int PURCL_CYC = 20  // Power-up recall wait
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic REQ_READY,
    input wire logic RDATA_VALID,
    input wire logic DONE,
    input wire logic DQ_OE,
    input wire logic SEL_N,
    input wire logic WR_N,
    input wire logic GATE_N,
    input wire logic HSB_OE,
    input wire logic HSB_I
);
    logic [7:0] hsb_cnt_reg;  // Cycles the host has held the busy line
    int         up_cnt_reg;   // Cycles since reset, saturating
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Saturating counters keep the waits checkable without long repetitions
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hsb_cnt_reg <= 8'h00;
            up_cnt_reg <= 0;
        end else begin
            hsb_cnt_reg <= !HSB_OE ? 8'h00 :
                           (hsb_cnt_reg == 8'hff) ? hsb_cnt_reg : hsb_cnt_reg + 8'h01;
            up_cnt_reg <= (up_cnt_reg > PURCL_CYC) ? up_cnt_reg : up_cnt_reg + 1;
        end
    end
    property p_wr_gate; !WR_N |-> GATE_N && !SEL_N; endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write strobe unselected or gated");
    property p_sel_len; $fell(SEL_N) |-> !SEL_N [*5] ##1 SEL_N; endproperty
    a_sel_len: assert property (p_sel_len) else $error("select pulse length wrong");
    property p_wr_close; $rose(WR_N) |-> $rose(SEL_N) ##1 !DQ_OE; endproperty
    a_wr_close: assert property (p_wr_close) else $error("write end order wrong");
    property p_rd_end; RDATA_VALID |-> SEL_N && GATE_N && !$past(SEL_N); endproperty
    a_rd_end: assert property (p_rd_end) else $error("read data not at select end");
    property p_rd_done; RDATA_VALID |-> ##2 DONE; endproperty
    a_rd_done: assert property (p_rd_done) else $error("read completion late");
    property p_hsb_len; $fell(HSB_OE) |-> hsb_cnt_reg >= 8'h19; endproperty
    a_hsb_len: assert property (p_hsb_len) else $error("busy pull too short");
    property p_pwrup; REQ_READY |-> up_cnt_reg >= PURCL_CYC; endproperty
    a_pwrup: assert property (p_pwrup) else $error("ready before power-up recall");
    property p_inhibit; (!HSB_I) [*4] ##0 SEL_N |=> SEL_N; endproperty
    a_inhibit: assert property (p_inhibit) else $error("access while busy");
endmodule
bind nvsac_host nvsac_host_properties #(.PURCL_CYC(PURCL_CYC)) u_props (
    .CLK(CLK), .ARST_N(ARST_N), .REQ_READY(REQ_READY), .RDATA_VALID(RDATA_VALID),
    .DONE(DONE), .DQ_OE(DQ_OE), .SEL_N(SEL_N), .WR_N(WR_N), .GATE_N(GATE_N),
    .HSB_OE(HSB_OE), .HSB_I(HSB_I));

// file: sim/nvsac_dev_model.sv
`timescale 1ns/1ns
`include "nvsac_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Device: SRAM cells with a shadow copy, unlock detector and busy line
module nvsac_dev_model (
    input  wire logic        clk,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  dq_in,
    input  wire logic        sel_n,
    input  wire logic        wr_n,
    input  wire logic        gate_n,
    input  wire logic        hsb_lvl,
    output logic [7:0]       dq_out,
    output logic             hsb_pull
);
    localparam logic [14:0] SEQ [5] = '{`NVSAC_SEQ_A0, `NVSAC_SEQ_A1, `NVSAC_SEQ_A2,
        `NVSAC_SEQ_A3, `NVSAC_SEQ_A4};
    logic [7:0]  mem [bit [14:0]];   // Cells, empty like the shadow at power-up
    logic [7:0]  nv [bit [14:0]];    // Shadow copy
    logic [14:0] last_a = 15'h0000;  // Previous access address
    logic [2:0]  idx = 3'd0;         // Prefix progress
    logic [1:0]  pend = 2'd0;        // Armed cycle: 1 store, 2 recall
    logic        sel_q = 1'b1;
    logic        wr_q = 1'b1;
    logic        wrote = 1'b0;       // Written since last store
    int          busy = 0;           // Store cycles left
    initial dq_out = 8'h00;
    initial hsb_pull = 1'b0;
    // Pins sampled once a clock; coarse but enough for a registered host
    always @(posedge clk) begin
        sel_q <= sel_n;
        wr_q <= wr_n;
        if (busy > 0) begin // Running store ignores pins, holds line
            busy <= busy - 1;
            hsb_pull <= busy > 1;
        end else if (!hsb_lvl) begin // Inhibit; copy only when dirty
            if (wrote) begin
                nv = mem;
                wrote <= 1'b0;
                busy <= 40;
                hsb_pull <= 1'b1;
            end
        end else if (sel_q && !sel_n) begin // Select edge clocks sequence, gate ignored
            last_a <= addr;
            if (wr_n && idx == 3'd5) // Sixth address picks the cycle, test code idle
                pend <= (addr == `NVSAC_SEQ_STORE) ? 2'h1 :
                        (addr == `NVSAC_SEQ_RECALL) ? 2'h2 : 2'h0;
            idx <= (wr_n && idx < 3'd5 && addr == SEQ[idx] && addr != last_a) ? idx + 3'd1
                 : {2'b00, wr_n && addr == SEQ[0]};
        end else if (!sel_q && sel_n && pend != 2'd0) begin // Starts as sixth access ends
            if (pend == 2'd1) begin // Store even when clean
                nv = mem;
                wrote <= 1'b0;
                busy <= 30;
                hsb_pull <= 1'b1;
            end else begin
                mem = nv;
            end
            pend <= 2'd0;
        end
        if (!wr_q && wr_n && hsb_lvl) begin // Latch as strobe ends
            mem[addr] = dq_in;
            wrote <= 1'b1;
        end
        // Drive only a gated read; a released bus toggles
        if (!sel_n && !gate_n && wr_n && hsb_lvl && busy == 0 && pend == 2'd0)
            dq_out <= mem.exists(addr) ? mem[addr] : addr[7:0];
        else
            dq_out <= ~dq_out;
    end
endmodule

// file: sim/nvsac_host_tb_top.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module nvsac_host_tb_top;
    import nvsac_pkg::*;
    typedef struct {nvsac_cmd_t cmd; logic [7:0] data;} nvsac_note_t;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    nvsac_req_t  req = '0;
    logic        req_valid = 1'b0;
    logic        req_ready, rdata_valid, done, dq_oe, sel_n, wr_n, gate_n, hsb_o, hsb_oe, pull;
    logic [7:0]  rdata, dq_o, dq_i;
    logic [14:0] a;
    wire         hsb_lvl = !((hsb_oe && !hsb_o) || pull);  // Pulled-up shared line
    wire [7:0]   dq_bus = dq_oe ? dq_o : ~dq_o;  // Released bus shows the inverse
    int          fails = 0, cmp_count = 0, cycles = 0, rd_seen = 0;
    int          seed = 32'h55ab3aca;
    logic        dirty = 1'b0;                 // Written since last store
    nvsac_note_t notes [$];                    // Expected completions, oldest first
    logic [7:0]  shadow [bit [14:0]];          // Expected cells
    logic [7:0]  saved [bit [14:0]];           // Expected shadow copy
    logic [14:0] addrs [4];
    always #20 clk = ~clk;
    nvsac_host #(.STORE_CYC(50), .PURCL_CYC(20)) u_dut (.CLK(clk), .ARST_N(arst_n), .REQ(req),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .RDATA(rdata), .RDATA_VALID(rdata_valid),
        .DONE(done), .A(a), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i), .SEL_N(sel_n), .WR_N(wr_n),
        .GATE_N(gate_n), .HSB_O(hsb_o), .HSB_OE(hsb_oe), .HSB_I(hsb_lvl));
    nvsac_dev_model u_dev (.clk(clk), .addr(a), .dq_in(dq_bus), .sel_n(sel_n), .wr_n(wr_n),
        .gate_n(gate_n), .hsb_lvl(hsb_lvl), .dq_out(dq_i), .hsb_pull(pull));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    // One request: note the expectation, hold until taken, wait for completion
    task automatic issue(input nvsac_cmd_t cmd, input logic [14:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        req <= '{cmd, ad, d};
        req_valid <= 1'b1;
        notes.push_back('{cmd, shadow.exists(ad) ? shadow[ad] : 8'h00});
        if (cmd == NVSAC_CMD_WRITE) begin
            shadow[ad] = d;
            dirty = 1'b1;
        end
        if (cmd == NVSAC_CMD_STORE || (cmd == NVSAC_CMD_HWSTR && dirty)) begin
            saved = shadow;
            dirty = 1'b0;
        end
        if (cmd == NVSAC_CMD_RECALL) shadow = saved;
        @(posedge clk);
        while (req_ready === 1'b1 && n < 3000) begin // Held until taken
            @(posedge clk);
            n++;
        end
        req_valid <= 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) check(1'b0, "command timed out");
    endtask
    // Each completion retires the oldest note; a read must have shown its data once
    always @(posedge clk) begin
        nvsac_note_t nt;
        cycles++;
        if (rdata_valid === 1'b1) rd_seen++;
        if (done === 1'b1) begin
            nt = notes.pop_front();
            if (nt.cmd == NVSAC_CMD_READ) check(rdata === nt.data && rd_seen == 1, "read data");
            else check(rd_seen == 0, "stray read data");
            rd_seen = 0;
        end
        if (cycles == 5000) begin // Whole run needs well under this
            fails++;
            $display("CHECK FAILED at %0t: run hung", $time);
            print_verdict();
        end
    end
    initial begin
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check(n >= 20, "ready before power-up recall");
        $display("test power-up done");
        for (int i = 0; i < 4; i++) begin
            addrs[i] = 15'($random(seed));
            issue(NVSAC_CMD_WRITE, addrs[i], 8'($random(seed)));
        end
        for (int i = 3; i >= 0; i--) issue(NVSAC_CMD_READ, addrs[i], 8'h00);
        $display("test write/read done");
        issue(NVSAC_CMD_STORE, 15'h0000, 8'h00);
        for (int i = 0; i < 4; i++) issue(NVSAC_CMD_WRITE, addrs[i], ~shadow[addrs[i]]);
        issue(NVSAC_CMD_RECALL, 15'h0000, 8'h00);
        for (int i = 0; i < 4; i++) issue(NVSAC_CMD_READ, addrs[i], 8'h00);
        $display("test software store/recall done");
        issue(NVSAC_CMD_WRITE, addrs[1], 8'ha5);
        issue(NVSAC_CMD_HWSTR, 15'h0000, 8'h00);
        issue(NVSAC_CMD_READ, addrs[1], 8'h00);
        issue(NVSAC_CMD_HWSTR, 15'h0000, 8'h00);
        issue(NVSAC_CMD_WRITE, addrs[1], 8'h3c);
        issue(NVSAC_CMD_RECALL, 15'h0000, 8'h00);
        issue(NVSAC_CMD_READ, addrs[1], 8'h00);
        $display("test pin store done");
        @(posedge clk);
        check(notes.size() == 0, "commands left unfinished");
        print_verdict();
    end
endmodule
